/* File: flash_host.v */
// Host controller that programs an asynchronous NOR flash byte by byte and polls its status.
// Assumes software on the same clock drives the register port; the flash pins are asynchronous.
//
// The implementer's own choices: the address map and the strobed register port.
`include "flash_host_regs.vh"

module flash_host #(
   parameter ADDR_W = 24,
   parameter DATA_W = 8,
   parameter [7:0] CLEAR_STATUS_CMD = 8'h50,
   parameter [7:0] QUERY_CMD = 8'h98,
   parameter [31:0] POLL_LIMIT = `POLL_LIMIT
) (
   input wire sys_clk_in, // System clock, 100 MHz
   input wire rst_n_in, // Asynchronous reset, active low
   input wire [7:0] reg_addr_in, // Register byte address
   input wire [31:0] reg_wdata_in, // Register write data
   input wire reg_wr_in, // Register write strobe
   input wire reg_rd_in, // Register read strobe
   output reg [31:0] reg_rdata_out, // Read data, the cycle after the strobe
   output wire [ADDR_W-1:0] fl_addr_out, // Flash address pins
   output wire [DATA_W-1:0] fl_dq_out, // Flash data pins, driven value
   output wire fl_dq_oe_n_out, // Data pin enable, low while driving
   input wire [DATA_W-1:0] fl_dq_in, // Flash data pins, sensed value
   output wire fl_ce_n_out, // Flash chip enable, active low
   output wire fl_oe_n_out, // Flash output enable, active low
   output wire fl_we_n_out // Flash write enable, active low
);

   localparam [6:0] S_IDLE = 7'b0000001;
   localparam [6:0] S_CMD = 7'b0000010;
   localparam [6:0] S_DATA = 7'b0000100;
   localparam [6:0] S_POLL = 7'b0001000;
   localparam [6:0] S_SUSP = 7'b0010000;
   localparam [6:0] S_TAIL = 7'b0100000;
   localparam [6:0] S_READ = 7'b1000000;

   reg [6:0] state_reg;
   reg [3:0] op_reg;
   reg wait_reg;
   reg [ADDR_W-1:0] addr_reg;
   reg [DATA_W-1:0] wdata_reg;
   reg [ADDR_W-1:0] prog_addr_reg;
   reg [DATA_W-1:0] rdata_reg;
   reg [7:0] last_sr_reg;
   reg susp_pend_reg;
   reg susp_sent_reg;
   reg suspended_reg;
   reg prog_fail_reg;
   reg supply_fail_reg;
   reg lock_fail_reg;
   reg seq_fail_reg;
   reg erase_fail_reg;
   reg erase_susp_reg;
   reg timeout_reg;
   reg refused_reg;
   reg [31:0] poll_cnt_reg;

   wire eng_busy;
   wire eng_done;
   wire [DATA_W-1:0] eng_rdata;
   wire [7:0] sr = eng_rdata[7:0];
   wire cmd_wr = reg_wr_in && (reg_addr_in == `REG_CMD);
   wire [3:0] new_op = reg_wdata_in[3:0];
   reg eng_wr;
   reg [DATA_W-1:0] eng_wdata;
   wire eng_start = (state_reg != S_IDLE) && !wait_reg && !eng_busy;

   // Sticky host error flags decoded from a final status byte
   function [4:0] sr_errors;
      input [7:0] s;
      begin
         sr_errors[0] = s[`SR_PROG_ERR] & ~s[`SR_ERASE_ERR];
         sr_errors[1] = s[`SR_SUPPLY_ERR];
         sr_errors[2] = s[`SR_LOCK_ERR];
         sr_errors[3] = s[`SR_PROG_ERR] & s[`SR_ERASE_ERR];
         sr_errors[4] = s[`SR_ERASE_ERR] & ~s[`SR_PROG_ERR];
      end
   endfunction

   wire [4:0] new_err = sr_errors(sr);
   // Array and query bytes are not status, so they must never touch the sticky flags
   wire status_read = (state_reg == S_POLL) || (state_reg == S_READ && op_reg == `OP_READ_STATUS);
   wire final_sr = eng_done && status_read && sr[`SR_READY];
   wire any_err = prog_fail_reg | supply_fail_reg | lock_fail_reg | seq_fail_reg | erase_fail_reg;

   // ==========================================================
   // Value put on the flash in each step
   always @* begin
      eng_wr = 1'b1;
      eng_wdata = {DATA_W{1'b0}};
      case (state_reg)
         S_CMD: begin
            case (op_reg)
               `OP_PROGRAM: eng_wdata[7:0] = `CMD_PROG_SETUP;
               `OP_RESUME: eng_wdata[7:0] = `CMD_PROG_RESUME;
               `OP_READ_STATUS: eng_wdata[7:0] = `CMD_READ_STATUS;
               `OP_CLEAR: eng_wdata[7:0] = CLEAR_STATUS_CMD;
               `OP_QUERY: eng_wdata[7:0] = QUERY_CMD;
               default: eng_wdata[7:0] = `CMD_READ_ARRAY;
            endcase
         end
         S_DATA: eng_wdata = wdata_reg;
         S_SUSP: eng_wdata[7:0] = `CMD_PROG_SUSPEND;
         S_TAIL: eng_wdata[7:0] = `CMD_READ_ARRAY;
         S_POLL: eng_wr = 1'b0;
         S_READ: eng_wr = 1'b0;
         default: eng_wr = 1'b1;
      endcase
   end

   // ==========================================================
   // Operation sequencer
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg <= S_IDLE;
         op_reg <= 4'h0;
         wait_reg <= 1'b0;
         prog_addr_reg <= {ADDR_W{1'b0}};
         rdata_reg <= {DATA_W{1'b0}};
         last_sr_reg <= 8'h00;
         susp_pend_reg <= 1'b0;
         susp_sent_reg <= 1'b0;
         suspended_reg <= 1'b0;
         timeout_reg <= 1'b0;
         refused_reg <= 1'b0;
         poll_cnt_reg <= 32'h0000_0000;
      end else begin
         if (eng_start) begin
            wait_reg <= 1'b1;
         end
         if (eng_done) begin
            wait_reg <= 1'b0;
         end
         case (state_reg)
            S_IDLE: begin
               if (cmd_wr) begin
                  op_reg <= new_op;
                  refused_reg <= 1'b0;
                  case (new_op)
                     `OP_PROGRAM: begin
                        // Retrying over uncleared errors would blur their cause
                        if (any_err || suspended_reg) begin
                           refused_reg <= 1'b1;
                        end else begin
                           prog_addr_reg <= addr_reg;
                           susp_sent_reg <= 1'b0;
                           susp_pend_reg <= 1'b0;
                           poll_cnt_reg <= 32'h0000_0000;
                           timeout_reg <= 1'b0;
                           state_reg <= S_CMD;
                        end
                     end
                     `OP_RESUME: begin
                        if (suspended_reg) begin
                           susp_sent_reg <= 1'b0;
                           susp_pend_reg <= 1'b0;
                           poll_cnt_reg <= 32'h0000_0000;
                           state_reg <= S_CMD;
                        end else begin
                           refused_reg <= 1'b1;
                        end
                     end
                     `OP_READ_ARRAY: begin
                        if (suspended_reg && addr_reg == prog_addr_reg) begin
                           refused_reg <= 1'b1;
                        end else begin
                           state_reg <= S_CMD;
                        end
                     end
                     `OP_READ_STATUS, `OP_CLEAR, `OP_QUERY: state_reg <= S_CMD;
                     default: refused_reg <= 1'b1;
                  endcase
               end
            end
            S_CMD: begin
               if (eng_done) begin
                  if (op_reg == `OP_PROGRAM) begin
                     state_reg <= S_DATA;
                  end else if (op_reg == `OP_RESUME) begin
                     suspended_reg <= 1'b0;
                     state_reg <= S_POLL;
                  end else if (op_reg == `OP_CLEAR) begin
                     state_reg <= S_IDLE;
                  end else begin
                     state_reg <= S_READ;
                  end
               end
            end
            S_DATA: begin
               if (eng_done) begin
                  state_reg <= S_POLL;
               end
            end
            S_POLL: begin
               if (eng_done) begin
                  last_sr_reg <= sr;
                  poll_cnt_reg <= poll_cnt_reg + 32'h0000_0001;
                  if (sr[`SR_READY]) begin
                     susp_pend_reg <= 1'b0;
                     if (susp_sent_reg && sr[`SR_PROG_SUSP]) begin
                        suspended_reg <= 1'b1;
                     end
                     state_reg <= S_TAIL;
                  end else if (poll_cnt_reg >= POLL_LIMIT - 32'h0000_0001) begin
                     timeout_reg <= 1'b1;
                     susp_pend_reg <= 1'b0;
                     state_reg <= S_TAIL;
                  end else if (susp_pend_reg && !susp_sent_reg) begin
                     state_reg <= S_SUSP;
                  end
               end
            end
            S_SUSP: begin
               if (eng_done) begin
                  susp_sent_reg <= 1'b1;
                  state_reg <= S_POLL;
               end
            end
            S_TAIL: begin
               if (eng_done) begin
                  state_reg <= S_IDLE;
               end
            end
            S_READ: begin
               if (eng_done) begin
                  rdata_reg <= eng_rdata;
                  if (op_reg == `OP_READ_STATUS) begin
                     last_sr_reg <= sr;
                  end
                  state_reg <= (op_reg == `OP_QUERY) ? S_TAIL : S_IDLE;
               end
            end
            default: begin
               state_reg <= S_IDLE;
            end
         endcase
         // Suspend is only meaningful while a program or resume is under way, from its command write through its polls
         if (cmd_wr && new_op == `OP_SUSPEND) begin
            if (state_reg == S_POLL || state_reg == S_DATA ||
                  (state_reg == S_CMD && (op_reg == `OP_PROGRAM || op_reg == `OP_RESUME))) begin
               susp_pend_reg <= 1'b1;
            end else begin
               refused_reg <= 1'b1;
            end
         end
      end
   end

   // ==========================================================
   // Sticky error flags: a new error wins over a clear in the same cycle
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         prog_fail_reg <= 1'b0;
         supply_fail_reg <= 1'b0;
         lock_fail_reg <= 1'b0;
         seq_fail_reg <= 1'b0;
         erase_fail_reg <= 1'b0;
         erase_susp_reg <= 1'b0;
      end else begin
         if (state_reg == S_CMD && op_reg == `OP_CLEAR && eng_done) begin
            prog_fail_reg <= 1'b0;
            supply_fail_reg <= 1'b0;
            lock_fail_reg <= 1'b0;
            seq_fail_reg <= 1'b0;
            erase_fail_reg <= 1'b0;
         end
         if (final_sr) begin
            erase_susp_reg <= sr[`SR_ERASE_SUSP];
            if (new_err[0]) prog_fail_reg <= 1'b1;
            if (new_err[1]) supply_fail_reg <= 1'b1;
            if (new_err[2]) lock_fail_reg <= 1'b1;
            if (new_err[3]) seq_fail_reg <= 1'b1;
            if (new_err[4]) erase_fail_reg <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Software register port
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         addr_reg <= {ADDR_W{1'b0}};
         wdata_reg <= {DATA_W{1'b0}};
         reg_rdata_out <= 32'h0000_0000;
      end else begin
         if (reg_wr_in && reg_addr_in == `REG_ADDR) begin
            addr_reg <= reg_wdata_in[ADDR_W-1:0];
         end
         if (reg_wr_in && reg_addr_in == `REG_WDATA) begin
            wdata_reg <= reg_wdata_in[DATA_W-1:0];
         end
         reg_rdata_out <= 32'h0000_0000;
         if (reg_rd_in) begin
            case (reg_addr_in)
               `REG_ADDR: reg_rdata_out[ADDR_W-1:0] <= addr_reg;
               `REG_WDATA: reg_rdata_out[DATA_W-1:0] <= wdata_reg;
               `REG_RDATA: reg_rdata_out[DATA_W-1:0] <= rdata_reg;
               `REG_STATUS: begin
                  reg_rdata_out[`ST_BUSY] <= (state_reg != S_IDLE);
                  reg_rdata_out[`ST_SUSPENDED] <= suspended_reg;
                  reg_rdata_out[`ST_PROG_FAIL] <= prog_fail_reg;
                  reg_rdata_out[`ST_SUPPLY_FAIL] <= supply_fail_reg;
                  reg_rdata_out[`ST_LOCK_FAIL] <= lock_fail_reg;
                  reg_rdata_out[`ST_SEQ_FAIL] <= seq_fail_reg;
                  reg_rdata_out[`ST_ERASE_FAIL] <= erase_fail_reg;
                  reg_rdata_out[`ST_TIMEOUT] <= timeout_reg;
                  reg_rdata_out[`ST_REFUSED] <= refused_reg;
                  reg_rdata_out[`ST_ERASE_SUSP] <= erase_susp_reg;
                  reg_rdata_out[`ST_LAST_SR_LSB+7:`ST_LAST_SR_LSB] <= last_sr_reg;
               end
               default: reg_rdata_out <= 32'h0000_0000;
            endcase
         end
      end
   end

   flash_bus_cycle #(
      .ADDR_W(ADDR_W),
      .DATA_W(DATA_W)
   ) u_cycle (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .start_in(eng_start),
      .wr_in(eng_wr),
      .addr_in(state_reg == S_DATA ? prog_addr_reg : addr_reg),
      .wdata_in(eng_wdata),
      .busy_out(eng_busy),
      .done_out(eng_done),
      .rdata_out(eng_rdata),
      .fl_addr_out(fl_addr_out),
      .fl_dq_out(fl_dq_out),
      .fl_dq_oe_n_out(fl_dq_oe_n_out),
      .fl_dq_in(fl_dq_in),
      .fl_ce_n_out(fl_ce_n_out),
      .fl_oe_n_out(fl_oe_n_out),
      .fl_we_n_out(fl_we_n_out)
   );

endmodule // flash_host

/* File: flash_host_regs.vh */
// Constants for the flash program and status host: register map, flash command bytes,
// status byte fields and bus-cycle timing.
// Assumes a 100 MHz system clock and an 8-bit data path to the flash.
`ifndef FLASH_HOST_REGS_VH
`define FLASH_HOST_REGS_VH

// ==========================================================
// Register map, byte offsets on the software port
`define REG_CMD 8'h00
`define REG_ADDR 8'h04
`define REG_WDATA 8'h08
`define REG_STATUS 8'h0C
`define REG_RDATA 8'h10

// ==========================================================
// Operation codes written to the command register
`define OP_PROGRAM 4'h1
`define OP_SUSPEND 4'h2
`define OP_RESUME 4'h3
`define OP_READ_ARRAY 4'h4
`define OP_READ_STATUS 4'h5
`define OP_CLEAR 4'h6
`define OP_QUERY 4'h7

// ==========================================================
// Flash command bytes
`define CMD_READ_STATUS 8'h70
`define CMD_PROG_SETUP 8'h40
`define CMD_READ_ARRAY 8'hFF
`define CMD_PROG_SUSPEND 8'hB0
`define CMD_PROG_RESUME 8'hD0

// ==========================================================
// Status byte bit positions
`define SR_READY 7
`define SR_ERASE_SUSP 6
`define SR_ERASE_ERR 5
`define SR_PROG_ERR 4
`define SR_SUPPLY_ERR 3
`define SR_PROG_SUSP 2
`define SR_LOCK_ERR 1

// ==========================================================
// Host status register bit positions
`define ST_BUSY 0
`define ST_SUSPENDED 1
`define ST_PROG_FAIL 2
`define ST_SUPPLY_FAIL 3
`define ST_LOCK_FAIL 4
`define ST_SEQ_FAIL 5
`define ST_ERASE_FAIL 6
`define ST_TIMEOUT 7
`define ST_REFUSED 8
`define ST_ERASE_SUSP 9
`define ST_LAST_SR_LSB 16

// ==========================================================
// Timing, in ns, and derived cycle counts (least times round up)
`define CLK_MHZ 100
`define T_SETUP_NS 10
`define T_WE_NS 70
`define T_ACC_NS 120
`define T_OEH_NS 20
`define SETUP_CYC ((`T_SETUP_NS * `CLK_MHZ + 999) / 1000)
`define WE_CYC ((`T_WE_NS * `CLK_MHZ + 999) / 1000)
`define ACC_CYC ((`T_ACC_NS * `CLK_MHZ + 999) / 1000)
`define OEH_CYC ((`T_OEH_NS * `CLK_MHZ + 999) / 1000)
`define SYNC_CYC 2
`define POLL_LIMIT 100000

`endif

/* File: flash_bus_cycle.v */
// One asynchronous flash bus cycle, a write or a read, on the parallel pins.
// Assumes start is a one-cycle pulse from logic on sys_clk_in, never given while busy.
`include "flash_host_regs.vh"

module flash_bus_cycle #(
   parameter ADDR_W = 24,
   parameter DATA_W = 8
) (
   input wire sys_clk_in, // System clock
   input wire rst_n_in, // Asynchronous reset, active low
   input wire start_in, // Start a cycle, one-cycle pulse
   input wire wr_in, // 1 write, 0 read
   input wire [ADDR_W-1:0] addr_in, // Cycle address
   input wire [DATA_W-1:0] wdata_in, // Write data
   output wire busy_out, // Cycle in progress
   output reg done_out, // Cycle finished, one-cycle pulse
   output reg [DATA_W-1:0] rdata_out, // Read data, valid at done
   output reg [ADDR_W-1:0] fl_addr_out, // Flash address pins
   output reg [DATA_W-1:0] fl_dq_out, // Flash data pins, driven value
   output reg fl_dq_oe_n_out, // Data pin enable, low while driving
   input wire [DATA_W-1:0] fl_dq_in, // Flash data pins, sensed value
   output reg fl_ce_n_out, // Chip enable, active low
   output reg fl_oe_n_out, // Output enable, active low
   output reg fl_we_n_out // Write enable, active low
);

   localparam integer SETUP_I = `SETUP_CYC;
   localparam integer WE_I = `WE_CYC;
   localparam integer SAMPLE_I = `ACC_CYC + `SYNC_CYC;
   localparam integer OEH_I = `OEH_CYC;
   localparam [7:0] SETUP_CYC = SETUP_I[7:0];
   localparam [7:0] WE_CYC = WE_I[7:0];
   localparam [7:0] SAMPLE_CYC = SAMPLE_I[7:0];
   localparam [7:0] OEH_CYC = OEH_I[7:0];

   localparam [4:0] PH_IDLE = 5'b00001;
   localparam [4:0] PH_SETUP = 5'b00010;
   localparam [4:0] PH_STROBE = 5'b00100;
   localparam [4:0] PH_RECOVER = 5'b01000;
   localparam [4:0] PH_END = 5'b10000;

   reg [4:0] phase_reg;
   reg [7:0] cnt_reg;
   reg wr_reg;
   reg [DATA_W-1:0] dq_meta_reg;
   reg [DATA_W-1:0] dq_sync_reg;

   assign busy_out = (phase_reg != PH_IDLE);

   // ==========================================================
   // Data pins come from the flash's own timing, so two flops first
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         dq_meta_reg <= {DATA_W{1'b0}};
         dq_sync_reg <= {DATA_W{1'b0}};
      end else begin
         dq_meta_reg <= fl_dq_in;
         dq_sync_reg <= dq_meta_reg;
      end
   end

   // ==========================================================
   // Cycle sequencer
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         phase_reg <= PH_IDLE;
         cnt_reg <= 8'h00;
         wr_reg <= 1'b0;
         done_out <= 1'b0;
         rdata_out <= {DATA_W{1'b0}};
         fl_addr_out <= {ADDR_W{1'b0}};
         fl_dq_out <= {DATA_W{1'b0}};
         fl_dq_oe_n_out <= 1'b1;
         fl_ce_n_out <= 1'b1;
         fl_oe_n_out <= 1'b1;
         fl_we_n_out <= 1'b1;
      end else begin
         done_out <= 1'b0;
         case (phase_reg)
            PH_IDLE: begin
               if (start_in) begin
                  wr_reg <= wr_in;
                  fl_addr_out <= addr_in;
                  fl_dq_out <= wdata_in;
                  fl_dq_oe_n_out <= ~wr_in;
                  fl_ce_n_out <= 1'b0;
                  cnt_reg <= SETUP_CYC;
                  phase_reg <= PH_SETUP;
               end
            end
            PH_SETUP: begin
               if (cnt_reg <= 8'h01) begin
                  fl_we_n_out <= ~wr_reg;
                  fl_oe_n_out <= wr_reg;
                  cnt_reg <= wr_reg ? WE_CYC : SAMPLE_CYC;
                  phase_reg <= PH_STROBE;
               end else begin
                  cnt_reg <= cnt_reg - 8'h01;
               end
            end
            PH_STROBE: begin
               if (cnt_reg <= 8'h01) begin
                  // Rising WE latches address and data; OE high ends the read
                  fl_we_n_out <= 1'b1;
                  fl_oe_n_out <= 1'b1;
                  if (!wr_reg) begin
                     rdata_out <= dq_sync_reg;
                  end
                  cnt_reg <= OEH_CYC;
                  phase_reg <= PH_RECOVER;
               end else begin
                  cnt_reg <= cnt_reg - 8'h01;
               end
            end
            PH_RECOVER: begin
               // Data held past WE rise; OE stays high long enough between polls
               if (cnt_reg <= 8'h01) begin
                  fl_dq_oe_n_out <= 1'b1;
                  fl_ce_n_out <= 1'b1;
                  phase_reg <= PH_END;
               end else begin
                  cnt_reg <= cnt_reg - 8'h01;
               end
            end
            PH_END: begin
               done_out <= 1'b1;
               phase_reg <= PH_IDLE;
            end
            default: begin
               phase_reg <= PH_IDLE;
            end
         endcase
      end
   end

endmodule // flash_bus_cycle

/* File: flash_host_checker.sv */
// Checker for flash_host, bound below.
// Assumes one clock and async active-low reset.
module flash_host_checker (
   input wire logic sys_clk_in, // Clock
   input wire logic rst_n_in, // Reset
   input wire logic reg_rd_in, // Read strobe
   input wire logic [31:0] reg_rdata_out, // Read data
   input wire logic [7:0] fl_dq_out, // Data out
   input wire logic fl_dq_oe_n_out, // Data enable
   input wire logic fl_ce_n_out, // Chip enable
   input wire logic fl_oe_n_out, // Output enable
   input wire logic fl_we_n_out // Write enable
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   a_rd_slot: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 0) else $error("stray data");
   a_we_width: assert property ($fell(fl_we_n_out) |-> !fl_we_n_out [*7] ##1 fl_we_n_out) else $error("we");
   a_data_hold: assert property ($fell(fl_we_n_out) |-> $stable(fl_dq_out) [*8] ##1 !fl_dq_oe_n_out)
      else $error("data hold");
   a_ce_first: assert property ($fell(fl_we_n_out) || $fell(fl_oe_n_out) |-> !$past(fl_ce_n_out))
      else $error("ce late");
   a_ce_hold: assert property ($rose(fl_we_n_out) |-> !fl_ce_n_out [*2]) else $error("ce hold");
   a_oe_width: assert property ($fell(fl_oe_n_out) |-> !fl_oe_n_out [*8]) else $error("oe");
   a_oe_gap: assert property ($rose(fl_oe_n_out) |-> fl_oe_n_out [*2]) else $error("oe gap");
   a_no_clash: assert property (!(!fl_oe_n_out && !fl_dq_oe_n_out)) else $error("clash");
   c_write: cover property ($fell(fl_we_n_out));
   c_read: cover property ($fell(fl_oe_n_out));
   c_data: cover property ($past(reg_rd_in) && reg_rdata_out != 0);
endmodule // flash_host_checker

bind flash_host flash_host_checker chk (.*);

/* File: flash_model.sv */
// Behavioural flash at its pins: commands, status byte, program time.
// Assumes the host holds address and data across the write pulse.
module flash_model #(
   parameter int BUSY_NS = 1500,
   parameter logic [23:0] LOCK_A = 24'h40,
   parameter logic [7:0] CLR = 8'h50,
   parameter logic [23:0] LOW_A = 24'h50,
   parameter logic [7:0] QRY = 8'h98,
   parameter logic [31:0] PROT_DESC = 32'h0303_0000
) (
   input wire logic ce_n_in, // Chip enable
   input wire logic oe_n_in, // Output enable
   input wire logic we_n_in, // Write enable
   input wire logic [23:0] a_in, // Address
   input wire logic [7:0] d_in, // Data in
   output logic [7:0] q_out // Data out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [logic [23:0]];
   logic [7:0] sr = 8'h80;
   logic stat = 0, pend = 0, sus = 0, qry = 0;
   longint done_t = 0, rem = 0;
   initial q_out = 8'h5A;
   function automatic logic [7:0] qtab(input logic [23:0] a);
      case (a)
         24'h15: return 8'h31;
         24'h36: return 8'hCE;
         24'h3F: return 8'h01;
         24'h40, 24'h41, 24'h42, 24'h43: return PROT_DESC[{a[1:0], 3'b000} +: 8];
         24'h44: return 8'h03;
         24'h45: return 8'h00;
         default: return 8'h00;
      endcase
   endfunction
   // No pull on the bus: a released bus shows the inverse
   always @(ce_n_in, oe_n_in, a_in) begin
      if (ce_n_in || oe_n_in) q_out = ~q_out;
      else if (stat) q_out = {sus || $time >= done_t, sr[6:3], sus, sr[1:0]};
      else if (qry) q_out = qtab(a_in);
      else q_out = mem.exists(a_in) ? mem[a_in] : 8'hFF;
   end
   always @(posedge we_n_in) if (!ce_n_in) begin
      stat = 1;
      qry = 0;
      if (pend) begin
         pend = 0;
         if (a_in == LOCK_A) sr = sr | 8'h12;
         else if (a_in == LOW_A) sr = sr | 8'h08;
         else begin
            mem[a_in] = d_in;
            done_t = $time + BUSY_NS;
         end
      end else case (d_in)
         8'h70: ;
         8'hFF: stat = 0;
         8'h40: pend = 1;
         8'hB0: if (!sus && $time < done_t) begin
            sus = 1;
            rem = done_t - $time;
         end
         8'hD0: if (sus) begin
            sus = 0;
            done_t = $time + rem;
         end
         CLR: sr = 8'h80;
         QRY: begin
            stat = 0;
            qry = 1;
         end
         default: sr = sr | 8'h30;
      endcase
   end
endmodule // flash_model

/* File: tb_flash_host.sv */
// Bench for flash_host with a behavioural flash.
// Assumes design, checker and model compiled first.
`include "flash_host_regs.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_flash_host;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk_in = 0, rst_n_in = 0, reg_wr_in = 0, reg_rd_in = 0;
   logic [7:0] reg_addr_in = 0, fl_dq_out, fl_dq_in;
   logic [31:0] reg_wdata_in = 0, reg_rdata_out, v;
   logic [23:0] fl_addr_out;
   logic fl_dq_oe_n_out, fl_ce_n_out, fl_oe_n_out, fl_we_n_out;
   int errors = 0, tests_run = 0;
   flash_host #(.POLL_LIMIT(20)) uut (.*);
   flash_model fm (.ce_n_in(fl_ce_n_out), .oe_n_in(fl_oe_n_out), .we_n_in(fl_we_n_out),
      .a_in(fl_addr_out), .d_in(fl_dq_out), .q_out(fl_dq_in));
   initial forever #5 sys_clk_in = ~sys_clk_in;
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_in);
      reg_wr_in <= 1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge sys_clk_in);
      reg_wr_in <= 0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk_in);
      reg_rd_in <= 1;
      reg_addr_in <= a;
      @(posedge sys_clk_in);
      reg_rd_in <= 0;
      #1 v = reg_rdata_out;
   endtask
   task automatic ck(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      `CHK(v, e)
   endtask
   task automatic conclude;
      $display("tests_run=%0d errors=%0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Bounded poll of the busy flag
   task automatic settle;
      for (int i = 0; i < 3000; i++) begin
         rd(`REG_STATUS);
         if (v[0] === 1'b0) return;
      end
      errors++;
      conclude;
   endtask
   task automatic go(input logic [23:0] a, input logic [7:0] d, input logic [3:0] o);
      wr(`REG_ADDR, {8'h00, a});
      wr(`REG_WDATA, {24'h00_0000, d});
      wr(`REG_CMD, {28'h000_0000, o});
      settle;
   endtask
   task automatic q(input logic [23:0] a, input logic [7:0] e);
      go(a, 0, `OP_QUERY);
      ck(`REG_RDATA, {24'h00_0000, e});
   endtask
   initial begin
      repeat (10) @(posedge sys_clk_in);
      rst_n_in <= 1;
      ck(`REG_STATUS, 0);
      ck(8'h14, 0);
      go(24'h10, 8'hA5, `OP_PROGRAM);
      ck(`REG_STATUS, 32'h0080_0000);
      go(24'h10, 0, `OP_READ_ARRAY);
      ck(`REG_RDATA, 32'h0000_00A5);
      $display("test program done");
      wr(`REG_ADDR, 32'h0000_0020);
      wr(`REG_WDATA, 32'h0000_003C);
      wr(`REG_CMD, {28'h000_0000, `OP_PROGRAM});
      wr(`REG_CMD, {28'h000_0000, `OP_SUSPEND});
      settle;
      ck(`REG_STATUS, 32'h0084_0002);
      go(24'h20, 0, `OP_READ_ARRAY);
      ck(`REG_STATUS, 32'h0084_0102);
      go(24'h20, 0, `OP_RESUME);
      ck(`REG_STATUS, 32'h0080_0000);
      go(24'h20, 0, `OP_READ_ARRAY);
      ck(`REG_RDATA, 32'h0000_003C);
      $display("test suspend done");
      go(24'h40, 8'h11, `OP_PROGRAM);
      ck(`REG_STATUS, 32'h0092_0014);
      go(24'h41, 8'h22, `OP_PROGRAM);
      ck(`REG_STATUS, 32'h0092_0114);
      go(0, 0, `OP_CLEAR);
      ck(`REG_STATUS, 32'h0092_0000);
      go(0, 0, `OP_READ_STATUS);
      ck(`REG_RDATA, 32'h0000_0080);
      go(24'h50, 8'h33, `OP_PROGRAM);
      ck(`REG_STATUS, 32'h0088_0008);
      $display("test errors done");
      q(24'h15, 8'h31);
      q(24'h3F, 8'h01);
      q(24'h40, 8'h00);
      q(24'h44, 8'h03);
      q(24'h45, 8'h00);
      go(24'h36, 0, `OP_QUERY);
      rd(`REG_RDATA);
      `CHK(v[7] & v[2], 1'b1)
      ck(`REG_STATUS, 32'h0088_0008);
      $display("test query done");
      conclude;
   end
endmodule // tb_flash_host
